// ### psg_pkg.sv
package psg_pkg;
    // clock and time bases
    localparam int CLK_MHZ = 250;
    localparam int DISCHARGE_PIN_ACT_MS = 100;
    localparam int DETACH_RET_US = 200;
    localparam int I2C_IDLE_MS = 1000;
    localparam int SUPPLY_LEAD_US = 100;
    localparam int DISCHARGE_PIN_ACT_CYC = DISCHARGE_PIN_ACT_MS * 1000 * CLK_MHZ;
    localparam int DETACH_RET_CYC = DETACH_RET_US * CLK_MHZ;
    localparam int I2C_IDLE_CYC = I2C_IDLE_MS * 1000 * CLK_MHZ;
    localparam int SUPPLY_LEAD_CYC = SUPPLY_LEAD_US * CLK_MHZ;
    localparam int CNT_W = 32;

    // adc and voltage codes, 1 mV per lsb
    localparam int ADC_W = 12;
    localparam logic [11:0] CC_DETACH_MV = 12'h4b0;
    localparam logic [11:0] NTC_LOW_MV = 12'h190;
    localparam logic [11:0] NTC_HIGH_MV = 12'h960;
    localparam int VREQ_W = 15;
    localparam logic [14:0] VOUT_DEFAULT_MV = 15'h1388;
    localparam logic [14:0] STEP_MIN_MV = 15'h0e10;
    localparam logic [14:0] STEP_MAX_MV = 15'h2ee0;
    localparam logic [14:0] STEP_SIZE_MV = 15'h00c8;

    // adaptive source current range
    localparam logic [1:0] ISRC_MAX = 2'h3;
    localparam logic [1:0] ISRC_MIN = 2'h0;

    // object table sizes
    localparam int NUM_PDO = 7;
    localparam int MAX_PPS = 4;

    // pin function codes
    typedef enum logic [1:0] {
        PSG_FN_OFF = 2'b00,
        PSG_FN_NTC = 2'b01,
        PSG_FN_NTC_OTP = 2'b10,
        PSG_FN_SUPPLY = 2'b11
    } psg_fn_t;

    typedef enum logic [1:0] {
        PSG_SUP_HIGH = 2'b00,
        PSG_SUP_DYN = 2'b01,
        PSG_SUP_INV = 2'b10
    } psg_sup_t;

    // dynamic supply states
    typedef enum logic [1:0] {
        PSG_DS_OFF = 2'b00,
        PSG_DS_LEAD = 2'b01,
        PSG_DS_ON = 2'b10
    } psg_ds_t;

    // vendor message selectors
    localparam logic [2:0] VDM_DIE = 3'h0;
    localparam logic [2:0] VDM_CONN = 3'h1;
    localparam logic [2:0] VDM_ADPT = 3'h2;
    localparam logic [2:0] VDM_VID = 3'h3;
    localparam logic [2:0] VDM_PID = 3'h4;
    localparam logic [2:0] VDM_BCD = 3'h5;
endpackage

// ### psg_pin.sv
`timescale 1ns/1ns
// one general-purpose pin: thermistor ranging, trip and supply control
module psg_pin
    import psg_pkg::*;
#(
    parameter int IDLE_CYC = I2C_IDLE_CYC,
    parameter int LEAD_CYC = SUPPLY_LEAD_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] func,
    input wire logic [1:0] sup_mode,
    input wire logic [ADC_W-1:0] pin_mv,
    input wire logic adc_valid,
    input wire logic [7:0] temp,
    input wire logic [7:0] trip_level,
    input wire logic i2c_req,
    input wire logic i2c_act,
    output logic [1:0] isrc,
    output logic otp_trip,
    output logic supply_out,
    output logic i2c_go
);
    psg_ds_t ds;
    logic [CNT_W-1:0] cnt;
    logic ntc_on;

    assign ntc_on = (func == PSG_FN_NTC) || (func == PSG_FN_NTC_OTP);

    // source current stepping on each new sample
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            isrc <= ISRC_MIN;
        end else if (!ntc_on) begin
            isrc <= ISRC_MIN;
        end else if (adc_valid) begin
            if (pin_mv < NTC_LOW_MV && isrc != ISRC_MAX) begin
                isrc <= isrc + 2'h1; // RQ9
            end else if (pin_mv > NTC_HIGH_MV && isrc != ISRC_MIN) begin
                isrc <= isrc - 2'h1; // RQ9
            end
        end
    end

    // hardware trip only in the trip variant
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            otp_trip <= 1'b0;
        end else begin
            otp_trip <= (func == PSG_FN_NTC_OTP) && (temp > trip_level); // RQ11
        end
    end

    // dynamic supply: power first, start transfer after lead time
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ds <= PSG_DS_OFF;
            cnt <= '0;
        end else if (func != PSG_FN_SUPPLY || sup_mode != PSG_SUP_DYN) begin
            ds <= PSG_DS_OFF;
            cnt <= '0;
        end else begin
            case (ds)
                PSG_DS_OFF: begin
                    cnt <= '0;
                    if (i2c_req) begin
                        ds <= PSG_DS_LEAD; // RQ13
                    end
                end
                PSG_DS_LEAD: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == CNT_W'(LEAD_CYC - 1)) begin
                        ds <= PSG_DS_ON;
                        cnt <= '0;
                    end
                end
                PSG_DS_ON: begin
                    // idle count restarts on any activity
                    if (i2c_act || i2c_req) begin
                        cnt <= '0; // RQ21
                    end else if (cnt == CNT_W'(IDLE_CYC - 1)) begin
                        ds <= PSG_DS_OFF; // RQ14
                    end else begin
                        cnt <= cnt + 1'b1; // RQ21
                    end
                end
                default: begin
                    ds <= PSG_DS_OFF;
                end
            endcase
        end
    end

    // registered pin drive and transfer release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            supply_out <= 1'b0;
            i2c_go <= 1'b0;
        end else begin
            i2c_go <= 1'b0;
            supply_out <= 1'b0;
            if (func == PSG_FN_SUPPLY) begin
                case (sup_mode)
                    PSG_SUP_HIGH: supply_out <= 1'b1; // RQ12
                    PSG_SUP_DYN: begin
                        supply_out <= (ds != PSG_DS_OFF); // RQ12
                        i2c_go <= (ds == PSG_DS_ON); // RQ13
                    end
                    PSG_SUP_INV: supply_out <= 1'b0; // RQ12
                    default: supply_out <= 1'b0;
                endcase
            end
        end
    end

    a_supply_lead: assert property (@(posedge clock) // RQ13
        disable iff (!rst_n) $rose(i2c_go) |-> supply_out)
        else $error("transfer released without supply");
    a_trip_mode: assert property (@(posedge clock) // RQ11
        disable iff (!rst_n) otp_trip |-> $past(func) == PSG_FN_NTC_OTP)
        else $error("trip outside trip mode");
    a_isrc_up: assert property (@(posedge clock) disable iff (!rst_n) // RQ9
        adc_valid && ntc_on && pin_mv < NTC_LOW_MV && isrc != ISRC_MAX
        && $stable(func) |=> isrc == $past(isrc) + 2'h1)
        else $error("source current not raised");
    a_idle_reset: assert property (@(posedge clock) // RQ21
        disable iff (!rst_n) ds == PSG_DS_ON && i2c_act |=> ds == PSG_DS_ON
        || func != PSG_FN_SUPPLY || sup_mode != PSG_SUP_DYN)
        else $error("supply dropped during activity");
    c_dyn_on: cover property (@(posedge clock) disable iff (!rst_n)
        $rose(i2c_go));
    c_dyn_off: cover property (@(posedge clock) disable iff (!rst_n)
        $fell(supply_out) && sup_mode == PSG_SUP_DYN);
endmodule

// ### psg_top.sv
`timescale 1ns/1ns
// ****************************************************************
// Summary of operation
// RQ1: sink discharge pin while both switches off
// RQ2: release discharge pin after limit when unattached
// RQ3: detach when either config line exceeds threshold; code masks detach in type-A mode
// RQ4: restore default output target after detach delay
// RQ5: detach and restore done in hardware only
// RQ6: die over-temperature trip when enabled
// RQ7: return die temperature on vendor request
// RQ8: each pin selects one of four functions
// RQ9: thermistor source current steps by thresholds
// RQ10: pin one connector, pin two adapter temperature
// RQ11: trip-mode compares thermistor temperature to level
// RQ12: supply output follows configured sub-mode
// RQ13: dynamic supply powers before bus transfer
// RQ14: dynamic supply off after idle second
// RQ15: type-A mode keeps load switch closed; code still opens it on protect or over-temperature trips
// RQ16: seven objects with limit type, compensation
// RQ17: at most four programmable objects
// RQ18: step requests clamped, stepped, capped
// RQ19: legacy fast-charge disableable by configuration
// RQ20: identity values returned on discovery
// RQ21: idle timer restarts on any bus activity
// ****************************************************************
module psg_top
    import psg_pkg::*;
#(
    parameter int DISCHARGE_PIN_CYC = DISCHARGE_PIN_ACT_CYC,
    parameter int RET_CYC = DETACH_RET_CYC,
    parameter int IDLE_CYC = I2C_IDLE_CYC,
    parameter int LEAD_CYC = SUPPLY_LEAD_CYC,
    parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
    parameter logic [15:0] PRODUCT_ID = 16'h0001, // arbitrary value
    parameter logic [15:0] RELEASE_BCD = 16'h0100 // arbitrary value
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADC_W-1:0] cc1_mv,
    input wire logic [ADC_W-1:0] cc2_mv,
    input wire logic cc_valid,
    input wire logic attached,
    input wire logic load_sw_req,
    input wire logic discharge_pin_req,
    input wire logic protect_trip,
    input wire logic type_a_mode,
    input wire logic [14:0] vout_req_mv,
    input wire logic vout_req_valid,
    input wire logic [7:0] die_temp,
    input wire logic die_otp_en,
    input wire logic [7:0] die_otp_level,
    input wire logic [1:0] conn_func,
    input wire logic [1:0] conn_sup_mode,
    input wire logic [7:0] conn_trip_level,
    input wire logic [ADC_W-1:0] connector_temp_pin,
    input wire logic [7:0] conn_temp,
    input wire logic [1:0] adpt_func,
    input wire logic [1:0] adpt_sup_mode,
    input wire logic [7:0] adpt_trip_level,
    input wire logic [ADC_W-1:0] adapter_temp_pin,
    input wire logic [7:0] adpt_temp,
    input wire logic adc_valid,
    input wire logic i2c_req,
    input wire logic i2c_act,
    input wire logic [NUM_PDO-1:0] pdo_cc_mode,
    input wire logic [NUM_PDO-1:0] pdo_cable_comp,
    input wire logic [NUM_PDO-1:0] pdo_pps_req,
    input wire logic legacy_fc_en,
    input wire logic [14:0] step_cap_mv,
    input wire logic [14:0] step_req_mv,
    input wire logic step_req_valid,
    input wire logic vdm_req,
    input wire logic [2:0] vdm_sel,
    output logic discharge_pin,
    output logic sink_1ma_en,
    output logic load_sw,
    output logic detach,
    output logic [14:0] vout_target_mv,
    output logic die_otp_trip,
    output logic conn_otp_trip,
    output logic adpt_otp_trip,
    output logic [1:0] conn_isrc,
    output logic [1:0] adpt_isrc,
    output logic connector_supply,
    output logic adapter_supply,
    output logic i2c_go,
    output logic [NUM_PDO-1:0] pdo_cc_eff,
    output logic [NUM_PDO-1:0] pdo_comp_eff,
    output logic [NUM_PDO-1:0] pdo_pps_eff,
    output logic legacy_fc_active,
    output logic vdm_ack,
    output logic [15:0] vdm_data
);
    // ****************************************************************
    // detach detection and default restore
    // ****************************************************************
    logic [CNT_W-1:0] ret_cnt;
    logic ret_pend;
    logic [CNT_W-1:0] dis_cnt;
    logic cc_high;
    logic conn_trip, adpt_trip, conn_sup, adpt_sup, conn_go, adpt_go;
    logic [1:0] c_isrc, a_isrc;
    logic [14:0] step_ok;
    logic [14:0] step_lim;

    // pure comparator, no firmware in the loop
    assign cc_high = cc_valid && ((cc1_mv > CC_DETACH_MV) ||
        (cc2_mv > CC_DETACH_MV)); // RQ3 RQ5

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            detach <= 1'b0;
        end else begin
            detach <= cc_high && !type_a_mode; // RQ3 RQ15
        end
    end

    // delay counter toward the default target
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ret_pend <= 1'b0;
            ret_cnt <= '0;
        end else if (detach && !ret_pend) begin
            ret_pend <= 1'b1; // RQ5
            ret_cnt <= '0;
        end else if (ret_pend) begin
            ret_cnt <= ret_cnt + 1'b1;
            if (ret_cnt == CNT_W'(RET_CYC - 2)) begin
                ret_pend <= 1'b0;
            end
        end
    end

    // step request clamp: cap, range, and grid
    always_comb begin
        step_lim = (step_cap_mv < STEP_MAX_MV) ? step_cap_mv : STEP_MAX_MV;
        step_ok = step_req_mv;
        if (step_ok > step_lim) begin
            step_ok = step_lim; // RQ18
        end
        if (step_ok < STEP_MIN_MV) begin
            step_ok = STEP_MIN_MV; // RQ18
        end
        step_ok = step_ok - 15'((step_ok - STEP_MIN_MV) % STEP_SIZE_MV);
    end

    // output voltage target; restore beats any request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vout_target_mv <= VOUT_DEFAULT_MV;
        end else if (ret_pend && ret_cnt == CNT_W'(RET_CYC - 2)) begin
            vout_target_mv <= VOUT_DEFAULT_MV; // RQ4
        end else if (!ret_pend && !detach) begin
            if (step_req_valid && legacy_fc_en) begin
                vout_target_mv <= step_ok; // RQ18 RQ19
            end else if (vout_req_valid) begin
                vout_target_mv <= vout_req_mv;
            end
        end
    end

    // ****************************************************************
    // load switch and discharge
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            load_sw <= 1'b0;
        end else if (protect_trip || die_otp_trip || conn_otp_trip ||
                     adpt_otp_trip) begin
            load_sw <= 1'b0;
        end else if (type_a_mode) begin
            load_sw <= 1'b1; // RQ15
        end else begin
            load_sw <= load_sw_req && !detach;
        end
    end

    // active time limit protects against an external bus voltage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dis_cnt <= '0;
        end else if (!discharge_pin_req || attached) begin
            dis_cnt <= '0;
        end else if (dis_cnt != CNT_W'(DISCHARGE_PIN_CYC)) begin
            dis_cnt <= dis_cnt + 1'b1; // RQ2
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            discharge_pin <= 1'b0;
            sink_1ma_en <= 1'b0;
        end else begin
            discharge_pin <= discharge_pin_req &&
                (attached || dis_cnt != CNT_W'(DISCHARGE_PIN_CYC)); // RQ2
            sink_1ma_en <= !load_sw && !discharge_pin; // RQ1
        end
    end

    // ****************************************************************
    // temperature and pins
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            die_otp_trip <= 1'b0;
        end else begin
            die_otp_trip <= die_otp_en && (die_temp > die_otp_level); // RQ6
        end
    end

    // identical pin logic, one instance each
    psg_pin #(.IDLE_CYC(IDLE_CYC), .LEAD_CYC(LEAD_CYC)) u_conn (
        .clock(clock), .rst_n(rst_n), .func(conn_func), // RQ8
        .sup_mode(conn_sup_mode), .pin_mv(connector_temp_pin),
        .adc_valid(adc_valid), .temp(conn_temp),
        .trip_level(conn_trip_level), .i2c_req(i2c_req),
        .i2c_act(i2c_act), .isrc(c_isrc), .otp_trip(conn_trip),
        .supply_out(conn_sup), .i2c_go(conn_go));
    psg_pin #(.IDLE_CYC(IDLE_CYC), .LEAD_CYC(LEAD_CYC)) u_adpt (
        .clock(clock), .rst_n(rst_n), .func(adpt_func), // RQ8
        .sup_mode(adpt_sup_mode), .pin_mv(adapter_temp_pin),
        .adc_valid(adc_valid), .temp(adpt_temp),
        .trip_level(adpt_trip_level), .i2c_req(i2c_req),
        .i2c_act(i2c_act), .isrc(a_isrc), .otp_trip(adpt_trip),
        .supply_out(adpt_sup), .i2c_go(adpt_go));

    // outputs re-registered so the top drives from flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            conn_otp_trip <= 1'b0;
            adpt_otp_trip <= 1'b0;
            conn_isrc <= ISRC_MIN;
            adpt_isrc <= ISRC_MIN;
            connector_supply <= 1'b0;
            adapter_supply <= 1'b0;
            i2c_go <= 1'b0;
        end else begin
            conn_otp_trip <= conn_trip;
            adpt_otp_trip <= adpt_trip;
            conn_isrc <= c_isrc;
            adpt_isrc <= a_isrc;
            // inverted sub-mode flips the level here
            connector_supply <= conn_sup ^ (conn_func == PSG_FN_SUPPLY &&
                conn_sup_mode == PSG_SUP_INV); // RQ12
            adapter_supply <= adpt_sup ^ (adpt_func == PSG_FN_SUPPLY &&
                adpt_sup_mode == PSG_SUP_INV); // RQ12
            i2c_go <= conn_go || adpt_go; // RQ13
        end
    end

    // ****************************************************************
    // power objects and fast charge
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pdo_cc_eff <= '0;
            pdo_comp_eff <= '0;
            pdo_pps_eff <= '0;
            legacy_fc_active <= 1'b0;
        end else begin
            pdo_cc_eff <= pdo_cc_mode; // RQ16
            pdo_comp_eff <= pdo_cable_comp; // RQ16
            pdo_pps_eff <= '0;
            // first four marked objects win, later marks stay fixed
            for (int i = 0, k = 0; i < NUM_PDO; i++) begin
                if (pdo_pps_req[i] && k < MAX_PPS) begin
                    pdo_pps_eff[i] <= 1'b1; // RQ17
                    k++;
                end
            end
            legacy_fc_active <= legacy_fc_en && attached; // RQ19
        end
    end

    // ****************************************************************
    // vendor message answers
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vdm_ack <= 1'b0;
            vdm_data <= '0;
        end else begin
            vdm_ack <= vdm_req;
            if (vdm_req) begin
                case (vdm_sel)
                    VDM_DIE: vdm_data <= {8'h00, die_temp}; // RQ7
                    VDM_CONN: vdm_data <= {8'h00, conn_temp}; // RQ10
                    VDM_ADPT: vdm_data <= {8'h00, adpt_temp}; // RQ10
                    VDM_VID: vdm_data <= VENDOR_ID; // RQ20
                    VDM_PID: vdm_data <= PRODUCT_ID; // RQ20
                    VDM_BCD: vdm_data <= RELEASE_BCD; // RQ20
                    default: vdm_data <= 16'h0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_detach_flag: assert property (@(posedge clock) // RQ3
        disable iff (!rst_n) cc_high && !type_a_mode |=> detach)
        else $error("detach not flagged");
    a_default_restore: assert property (@(posedge clock) // RQ4
        disable iff (!rst_n)
        $rose(ret_pend) |-> ##[1:1000] vout_target_mv == VOUT_DEFAULT_MV)
        else $error("default target not restored");
    a_sink_when_off: assert property (@(posedge clock) // RQ1
        disable iff (!rst_n) !load_sw && !discharge_pin |=> sink_1ma_en)
        else $error("sink not enabled");
    a_die_trip: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
        die_otp_en && die_temp > die_otp_level |=> die_otp_trip)
        else $error("die trip missed");
    a_type_a_closed: assert property (@(posedge clock) // RQ15
        disable iff (!rst_n) type_a_mode && !protect_trip && !die_otp_trip
        && !conn_otp_trip && !adpt_otp_trip |=> load_sw)
        else $error("load switch open in type-a mode");
    a_pps_count: assert property (@(posedge clock) // RQ17
        disable iff (!rst_n) $countones(pdo_pps_eff) <= MAX_PPS)
        else $error("too many programmable objects");
    a_step_range: assert property (@(posedge clock) // RQ18
        disable iff (!rst_n)
        step_req_valid && legacy_fc_en && !ret_pend && !detach
        |=> vout_target_mv >= STEP_MIN_MV && vout_target_mv <= STEP_MAX_MV)
        else $error("step target out of range");
    a_vdm_die: assert property (@(posedge clock) disable iff (!rst_n) // RQ7
        vdm_req && vdm_sel == VDM_DIE |=> vdm_ack
        && vdm_data[7:0] == $past(die_temp))
        else $error("die temperature answer wrong");
    a_discharge_pin_limit: assert property (@(posedge clock) // RQ2
        disable iff (!rst_n) dis_cnt == CNT_W'(DISCHARGE_PIN_CYC) && !attached
        |=> !discharge_pin) else $error("discharge held too long");
    c_detach: cover property (@(posedge clock) disable iff (!rst_n)
        $rose(detach));
    c_discharge_pin_release: cover property (@(posedge clock) disable iff (!rst_n)
        $fell(discharge_pin) && discharge_pin_req);
    c_vdm_id: cover property (@(posedge clock) disable iff (!rst_n)
        vdm_req && vdm_sel == VDM_VID);
endmodule

// ### psg_sink_model.sv
`timescale 1ns/1ns
// sink on the config lines: pull-down when plugged, source pull-up if not
module psg_sink_model (
    input wire logic clock,
    input wire logic plug,
    output logic [11:0] cc1_mv,
    output logic [11:0] cc2_mv,
    output logic cc_valid,
    output logic attached
);
    // nonblocking update on the edge, so a plug change never races the bench
    always @(posedge clock) begin
        cc1_mv <= plug ? 12'h190 : 12'hce4;
        cc2_mv <= 12'h000;
        cc_valid <= 1'b1;
        attached <= plug;
    end
endmodule

// ### tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb;
    import psg_pkg::*;
    localparam int RET = 20;
    localparam int LEAD = 10;
    localparam int IDLE = 100;
    logic clock = 0, rst_n = 0, plug = 1;
    logic [11:0] cc1_mv, cc2_mv, connector_temp_pin, adapter_temp_pin;
    logic [14:0] vout_req_mv, step_cap_mv, step_req_mv, vout_target_mv;
    logic [7:0] die_temp, die_otp_level, conn_trip_level, conn_temp;
    logic [7:0] adpt_trip_level, adpt_temp;
    logic [1:0] conn_func, conn_sup_mode, adpt_func, adpt_sup_mode;
    logic [1:0] conn_isrc, adpt_isrc;
    logic [6:0] pdo_cc_mode, pdo_cable_comp, pdo_pps_req;
    logic [6:0] pdo_cc_eff, pdo_comp_eff, pdo_pps_eff;
    logic [2:0] vdm_sel;
    logic [15:0] vdm_data;
    logic cc_valid, attached, load_sw_req, discharge_pin_req, protect_trip;
    logic type_a_mode, vout_req_valid, die_otp_en, adc_valid, i2c_req;
    logic i2c_act, legacy_fc_en, step_req_valid, vdm_req, discharge_pin;
    logic sink_1ma_en, load_sw, detach, die_otp_trip, conn_otp_trip;
    logic adpt_otp_trip, connector_supply, adapter_supply, i2c_go;
    logic legacy_fc_active, vdm_ack;
    int error_cnt = 0, tests_run = 0;

    psg_top #(.DISCHARGE_PIN_CYC(50), .RET_CYC(RET), .IDLE_CYC(IDLE),
        .LEAD_CYC(LEAD)) i_psg_top (.*);
    psg_sink_model i_psg_sink_model (.clock, .plug, .cc1_mv, .cc2_mv,
        .cc_valid, .attached);

    // 250 MHz system clock
    always #2 clock = ~clock;

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    // pulse inputs are raised for exactly one sampling edge
    task automatic step(input logic [14:0] v);
        step_req_mv = v;
        step_req_valid = 1;
        tick(1);
        step_req_valid = 0;
        tick(1);
    endtask
    task automatic vdm(input logic [2:0] s, input logic [15:0] e);
        vdm_sel = s;
        vdm_req = 1;
        tick(1);
        vdm_req = 0;
        `CHK("vdm_ack", 1'b1, vdm_ack)
        `CHK("vdm_data", e, vdm_data)
        tick(1);
    endtask
    task automatic adc(input logic [11:0] mv);
        connector_temp_pin = mv;
        adc_valid = 1;
        tick(1);
        adc_valid = 0;
        tick(3);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // watchdog: tests need under 2000 cycles
    initial begin
        #40000;
        error_cnt++;
        results();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        {load_sw_req, discharge_pin_req, protect_trip, type_a_mode} = 0;
        {vout_req_valid, die_otp_en, adc_valid, i2c_req, i2c_act} = 0;
        {step_req_valid, vdm_req} = 0;
        {vout_req_mv, step_req_mv, vdm_sel} = 0;
        legacy_fc_en = 1;
        step_cap_mv = 15'h2328;
        die_temp = 8'h64;
        die_otp_level = 8'h50;
        {conn_func, conn_sup_mode, adpt_func, adpt_sup_mode} = 0;
        {conn_trip_level, adpt_trip_level} = {8'h50, 8'h50};
        {conn_temp, adpt_temp} = {8'h5a, 8'h21};
        {connector_temp_pin, adapter_temp_pin} = {12'h3e8, 12'h3e8};
        pdo_cc_mode = 7'h55;
        pdo_cable_comp = 7'h2a;
        pdo_pps_req = 7'h7f;
        tick(5);
        rst_n = 1;
        tick(1);
        `CHK("vout_reset", 15'h1388, vout_target_mv)
        `CHK("pdo_cc", 7'h55, pdo_cc_eff)
        `CHK("pdo_comp", 7'h2a, pdo_comp_eff)
        `CHK("pdo_pps", 7'h0f, pdo_pps_eff)
        `CHK("legacy_fc", 1'b1, legacy_fc_active)
        step(15'h4e20);
        `CHK("step_cap", 15'h2328, vout_target_mv)
        step(15'h0bb8);
        `CHK("step_min", 15'h0e10, vout_target_mv)
        step(15'h13ec);
        `CHK("step_grid", 15'h1388, vout_target_mv)
        legacy_fc_en = 0;
        step(15'h2328);
        `CHK("fc_off", 15'h1388, vout_target_mv)
        legacy_fc_en = 1;
        step(15'h2328);
        vdm(VDM_DIE, 16'h0064);
        vdm(VDM_CONN, 16'h005a);
        vdm(VDM_ADPT, 16'h0021);
        vdm(VDM_VID, 16'h1234);
        vdm(VDM_PID, 16'h0001);
        vdm(VDM_BCD, 16'h0100);
        $display("test step and vdm done");
        plug = 0;
        tick(3);
        `CHK("detach", 1'b1, detach)
        tick(8);
        `CHK("vout_held", 15'h2328, vout_target_mv)
        tick(RET);
        `CHK("vout_safe", 15'h1388, vout_target_mv)
        discharge_pin_req = 1;
        tick(2);
        `CHK("discharge_pin_on", 1'b1, discharge_pin)
        tick(60);
        `CHK("discharge_pin_off", 1'b0, discharge_pin)
        discharge_pin_req = 0;
        tick(3);
        `CHK("sink", 1'b1, sink_1ma_en)
        type_a_mode = 1;
        tick(3);
        `CHK("detach_masked", 1'b0, detach)
        `CHK("load_sw_a", 1'b1, load_sw)
        protect_trip = 1;
        tick(3);
        `CHK("load_sw_trip", 1'b0, load_sw)
        $display("test detach and discharge done");
        die_otp_en = 1;
        conn_func = PSG_FN_NTC;
        adc(12'h12c);
        adc(12'h12c);
        `CHK("isrc_up", 2'h2, conn_isrc)
        adc(12'h9c4);
        `CHK("isrc_down", 2'h1, conn_isrc)
        `CHK("ntc_no_trip", 1'b0, conn_otp_trip)
        conn_func = PSG_FN_NTC_OTP;
        adpt_temp = 8'h5a;
        tick(4);
        `CHK("conn_trip", 1'b1, conn_otp_trip)
        `CHK("adpt_no_trip", 1'b0, adpt_otp_trip)
        `CHK("adpt_isrc", 2'h0, adpt_isrc)
        `CHK("die_trip", 1'b1, die_otp_trip)
        $display("test thermistor done");
        adpt_func = PSG_FN_SUPPLY;
        tick(3);
        `CHK("sup_high", 1'b1, adapter_supply)
        `CHK("conn_sup", 1'b0, connector_supply)
        adpt_sup_mode = PSG_SUP_DYN;
        tick(3);
        `CHK("sup_idle", 1'b0, adapter_supply)
        i2c_req = 1;
        tick(1);
        i2c_req = 0;
        tick(3);
        `CHK("sup_on", 1'b1, adapter_supply)
        `CHK("go_wait", 1'b0, i2c_go)
        tick(LEAD + 2);
        `CHK("go", 1'b1, i2c_go)
        tick(60);
        i2c_act = 1;
        tick(1);
        i2c_act = 0;
        tick(80);
        `CHK("sup_kept", 1'b1, adapter_supply)
        tick(30);
        `CHK("sup_off", 1'b0, adapter_supply)
        adpt_sup_mode = PSG_SUP_INV;
        tick(3);
        `CHK("sup_inv", 1'b1, adapter_supply)
        $display("test supply done");
        results();
    end
endmodule
